/* File: hdl/eeprom_host_pkg.sv */
// eeprom_host_pkg: constants, register map and carrier types for the paged eeprom host.
// assumes a 20 MHz system clock and a byte-wide asynchronous paged eeprom on plain pins.
package eeprom_host_pkg;

  // clock and pin timing, figures in their own units
  localparam int CLK_MHZ   = 20;
  localparam int T_WP_NS   = 100;          // least write strobe low
  localparam int T_WPH_NS  = 50;           // least write strobe high
  localparam int T_ACC_NS  = 150;          // longest address/enable to data
  localparam int T_OEHP_NS = 150;          // least output-enable high between polls
  localparam int T_BLC_US  = 150;          // longest byte_load_window
  localparam int T_WC_MS   = 10;           // longest program_cycle_time

  // cycle counts: least times and the longest access time round up, the other longest times round down
  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WPH_CYC  = 8'((T_WPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ACC_CYC  = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] OEHP_CYC = 8'((T_OEHP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] BLC_CYC      = 12'(T_BLC_US * CLK_MHZ);
  localparam logic [11:0] BLC_SAFE_CYC = 12'(T_BLC_US * CLK_MHZ / 2);
  localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;

  localparam int          PAGE_BYTES = 128;
  localparam logic [7:0]  CMD_LEN    = 8'h03;
  localparam logic [7:0]  MAX_COUNT  = 8'h80;

  // register word indexes on the avalon slave
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h01;
  localparam logic [7:0] REG_COUNT  = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_RDATA  = 8'h04;
  localparam int         BUF_SEL_BIT = 7;  // index 0x80..0xff is the page buffer

  // control fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_POLLDATA = 4;
  localparam int CTRL_PREFIX   = 5;
  localparam int CTRL_GO       = 8;

  // status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_BADCNT  = 3;
  localparam int ST_LOCKED  = 4;
  localparam int ST_GAPERR  = 5;

  typedef enum logic [1:0] {
    OP_READ     = 2'h0,
    OP_WRITE    = 2'h1,
    OP_LOCK_ON  = 2'h2,
    OP_LOCK_OFF = 2'h3
  } hostOp_t;

  typedef struct packed {
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic [16:0] addr;
    logic [7:0]  dout;
    logic        doutEn;
  } memPins_t;

  localparam memPins_t MEM_PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
                                         addr: 17'h00000, dout: 8'h00, doutEn: 1'b0};

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writeData;
  } avsReq_t;

endpackage

/* File: hdl/phase_timer.sv */
// phase_timer: loadable down counter that times one phase of a pin cycle.
// assumes the caller loads the phase length minus one on entering the phase.
`timescale 1ns/100ps
module phase_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,  // system clock
  input  wire logic             arst_n,   // async reset, active low
  input  wire logic             load,     // load a new phase length
  input  wire logic [WIDTH-1:0] loadVal,  // cycles in phase minus one
  output logic                  done      // last cycle of the phase
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // count down to zero and rest there
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadVal;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule

/* File: hdl/eeprom_write_host.sv */
// eeprom_write_host: avalon-mm controlled host that reads, page-writes and locks a paged eeprom.
// assumes the eeprom pins are wired directly and memDin is synchronous to sys_clk.
// Contract
// - all bytes of a page load keep the same page-select address at every strobe fall.
// - each page byte starts within the byte_load_window of the previous one.
// - a protected or plain page write carries one to 128 data bytes.
// - the first three bytes of a command carry the exact command addresses.
// - output enable stays high whenever write and chip strobes are both low.
// - command addresses drive the low fifteen lines, command data all eight lines.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module eeprom_write_host
  import eeprom_host_pkg::*;
#(
  parameter int          PROG_TIMEOUT  = eeprom_host_pkg::WC_CYC,
  parameter logic [44:0] LOCK_ON_ADDR  = {15'h0111, 15'h0222, 15'h0333},  // arbitrary
  parameter logic [23:0] LOCK_ON_DATA  = {8'h11, 8'h22, 8'h33},           // arbitrary
  parameter logic [44:0] LOCK_OFF_ADDR = {15'h0111, 15'h0222, 15'h0444},  // arbitrary
  parameter logic [23:0] LOCK_OFF_DATA = {8'h11, 8'h22, 8'h44}            // arbitrary
) (
  input  wire logic                      sys_clk,         // system clock, 20 MHz
  input  wire logic                      arst_n,          // async reset, active low
  input  wire eeprom_host_pkg::avsReq_t  avsReq,          // avalon address, read, write, data
  output logic [31:0]                    avsReadData,     // avalon read data
  output logic                           avsWaitRequest,  // avalon wait request
  output eeprom_host_pkg::memPins_t      memPins,         // eeprom strobes, address, data out
  input  wire logic [7:0]                memDin           // eeprom data lines as read
);
  import eeprom_host_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_WSET  = 6'b000010,
    S_WLOW  = 6'b000100,
    S_WHIGH = 6'b001000,
    S_RACC  = 6'b010000,
    S_RGAP  = 6'b100000
  } seqState_t;

  // command address and data of one step, first step in the top bits
  function automatic logic [14:0] cmdAddr(input logic off, input logic [1:0] idx);
    logic [44:0] vec;
    vec = off ? LOCK_OFF_ADDR : LOCK_ON_ADDR;
    return vec[(2 - idx) * 15 +: 15];
  endfunction

  function automatic logic [7:0] cmdData(input logic off, input logic [1:0] idx);
    logic [23:0] vec;
    vec = off ? LOCK_OFF_DATA : LOCK_ON_DATA;
    return vec[(2 - idx) * 8 +: 8];
  endfunction

  // bus-side register state
  logic        prefix_q, prefix_d, pollSel_q, pollSel_d, rdPend_q, rdPend_d;
  logic [1:0]  ctrlOp_q, ctrlOp_d;
  logic [16:0] addrReg_q, addrReg_d;
  logic [7:0]  count_q, count_d;
  logic [31:0] readData_q, readData_d;
  logic [7:0]  pageBuf_q [PAGE_BYTES];
  logic [7:0]  pageBuf_d [PAGE_BYTES];
  // sequencer state
  seqState_t   state_q, state_d;
  hostOp_t     op_q, op_d;
  logic        pollData_q, pollData_d, firstPoll_q, firstPoll_d, prev6_q, prev6_d;
  logic        done_q, done_d, timeout_q, timeout_d, badCnt_q, badCnt_d;
  logic        gapErr_q, gapErr_d, locked_q, locked_d;
  logic [7:0]  preLen_q, preLen_d, itemIdx_q, itemIdx_d, itemTotal_q, itemTotal_d;
  logic [7:0]  lastData_q, lastData_d, readByte_q, readByte_d;
  logic [16:0] rdAddr_q, rdAddr_d;
  logic [23:0] progCnt_q, progCnt_d;
  logic [11:0] gapCnt_q, gapCnt_d;
  memPins_t    pins_q, pins_d;
  logic        tmrLoad, tmrDone, busy, goReq, cntOk, pollOk;
  logic [7:0]  tmrVal, k;
  hostOp_t     goOp;

  phase_timer #(.WIDTH(8)) u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .done    (tmrDone)
  );

  // avalon handshake: reads take one wait cycle, writes stall while a job runs
  assign busy           = (state_q != S_IDLE);
  assign avsWaitRequest = (avsReq.read & ~rdPend_q) | (avsReq.write & busy);
  assign goReq          = avsReq.write & ~busy & (avsReq.address == REG_CTRL)
                          & avsReq.writeData[CTRL_GO];
  assign goOp           = hostOp_t'(avsReq.writeData[CTRL_OP_LSB +: 2]);
  assign cntOk          = (count_q != 8'h00) && (count_q <= MAX_COUNT);
  assign avsReadData    = readData_q;
  assign memPins        = pins_q;

  // register writes and registered read-back
  always_comb begin
    prefix_d = prefix_q; pollSel_d = pollSel_q; ctrlOp_d = ctrlOp_q;
    addrReg_d = addrReg_q; count_d = count_q; pageBuf_d = pageBuf_q;
    readData_d = readData_q; rdPend_d = 1'b0;
    if (avsReq.write && !busy) begin
      if (avsReq.address[BUF_SEL_BIT]) begin
        pageBuf_d[avsReq.address[6:0]] = avsReq.writeData[7:0];
      end else if (avsReq.address == REG_CTRL) begin
        ctrlOp_d  = avsReq.writeData[CTRL_OP_LSB +: 2];
        pollSel_d = avsReq.writeData[CTRL_POLLDATA];
        prefix_d  = avsReq.writeData[CTRL_PREFIX];
      end else if (avsReq.address == REG_ADDR) begin
        addrReg_d = avsReq.writeData[16:0];
      end else if (avsReq.address == REG_COUNT) begin
        count_d = avsReq.writeData[7:0];
      end
    end
    if (avsReq.read && !rdPend_q) begin
      rdPend_d   = 1'b1;
      readData_d = 32'h00000000;
      if (avsReq.address[BUF_SEL_BIT]) begin
        readData_d[7:0] = pageBuf_q[avsReq.address[6:0]];
      end else if (avsReq.address == REG_CTRL) begin
        readData_d[CTRL_OP_LSB +: 2] = ctrlOp_q;
        readData_d[CTRL_POLLDATA]    = pollSel_q;
        readData_d[CTRL_PREFIX]      = prefix_q;
      end else if (avsReq.address == REG_ADDR) begin
        readData_d[16:0] = addrReg_q;
      end else if (avsReq.address == REG_COUNT) begin
        readData_d[7:0] = count_q;
      end else if (avsReq.address == REG_STATUS) begin
        readData_d[ST_BUSY]    = busy;
        readData_d[ST_DONE]    = done_q;
        readData_d[ST_TIMEOUT] = timeout_q;
        readData_d[ST_BADCNT]  = badCnt_q;
        readData_d[ST_LOCKED]  = locked_q;
        readData_d[ST_GAPERR]  = gapErr_q;
      end else if (avsReq.address == REG_RDATA) begin
        readData_d[7:0] = readByte_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prefix_q <= 1'b0; pollSel_q <= 1'b0; ctrlOp_q <= 2'h0; rdPend_q <= 1'b0;
      addrReg_q <= 17'h00000; count_q <= 8'h01; readData_q <= 32'h00000000;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pageBuf_q[i] <= 8'h00;
      end
    end else begin
      prefix_q <= prefix_d; pollSel_q <= pollSel_d; ctrlOp_q <= ctrlOp_d;
      rdPend_q <= rdPend_d; addrReg_q <= addrReg_d; count_q <= count_d;
      readData_q <= readData_d; pageBuf_q <= pageBuf_d;
    end
  end

  // job sequencer: write strobes, then read polls until programming ends
  always_comb begin
    state_d = state_q; op_d = op_q; pollData_d = pollData_q; firstPoll_d = firstPoll_q;
    prev6_d = prev6_q; done_d = done_q; timeout_d = timeout_q; badCnt_d = badCnt_q;
    gapErr_d = gapErr_q; locked_d = locked_q; preLen_d = preLen_q; itemIdx_d = itemIdx_q;
    itemTotal_d = itemTotal_q; lastData_d = lastData_q; readByte_d = readByte_q;
    rdAddr_d = rdAddr_q; tmrLoad = 1'b0; tmrVal = 8'h00; pollOk = 1'b0;
    progCnt_d = (state_q == S_RACC || state_q == S_RGAP) ? progCnt_q + 24'h1 : 24'h0;
    case (state_q)
      S_IDLE: begin
        if (goReq) begin
          op_d = goOp; pollData_d = avsReq.writeData[CTRL_POLLDATA];
          done_d = 1'b0; timeout_d = 1'b0; badCnt_d = 1'b0; gapErr_d = 1'b0;
          itemIdx_d = 8'h00; firstPoll_d = 1'b1;
          if (goOp == OP_READ) begin
            rdAddr_d = addrReg_q; tmrLoad = 1'b1; tmrVal = ACC_CYC - 8'h1;
            state_d  = S_RACC;
          end else if (goOp == OP_WRITE && !cntOk) begin
            badCnt_d = 1'b1;
            done_d   = 1'b1;
          end else if (goOp == OP_WRITE) begin
            preLen_d    = avsReq.writeData[CTRL_PREFIX] ? CMD_LEN : 8'h00;
            itemTotal_d = preLen_d + count_q;
            state_d     = S_WSET;
          end else begin
            preLen_d = CMD_LEN; itemTotal_d = CMD_LEN; state_d = S_WSET;
          end
        end
      end
      S_WSET: begin
        tmrLoad = 1'b1; tmrVal = WP_CYC - 8'h1; state_d = S_WLOW;
      end
      S_WLOW: begin
        if (tmrDone) begin
          tmrLoad = 1'b1; tmrVal = WPH_CYC - 8'h1; state_d = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (tmrDone && itemIdx_q + 8'h1 < itemTotal_q) begin
          itemIdx_d = itemIdx_q + 8'h1; state_d = S_WSET;
        end else if (tmrDone) begin
          // poll the last byte written
          rdAddr_d = pins_q.addr; lastData_d = pins_q.dout;
          tmrLoad = 1'b1; tmrVal = ACC_CYC - 8'h1; state_d = S_RACC;
        end
      end
      S_RACC: begin
        if (tmrDone) begin
          readByte_d = memDin; prev6_d = memDin[6]; firstPoll_d = 1'b0;
          pollOk = pollData_q ? (memDin[7] == lastData_q[7])
                              : (!firstPoll_q && memDin[6] == prev6_q);
          if (op_q == OP_READ || pollOk) begin
            state_d = S_IDLE; done_d = 1'b1;
            if (op_q == OP_LOCK_ON) locked_d = 1'b1;
            if (op_q == OP_LOCK_OFF) locked_d = 1'b0;
          end else if (progCnt_q >= 24'(PROG_TIMEOUT)) begin
            state_d = S_IDLE; done_d = 1'b1; timeout_d = 1'b1;
          end else begin
            tmrLoad = 1'b1; tmrVal = OEHP_CYC - 8'h1; state_d = S_RGAP;
          end
        end
      end
      S_RGAP: begin
        if (tmrDone) begin
          tmrLoad = 1'b1; tmrVal = ACC_CYC - 8'h1; state_d = S_RACC;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // spacing since the last strobe fall, kept well inside the load window
    if (state_d == S_WLOW && state_q != S_WLOW) begin
      gapCnt_d = 12'h000;
    end else if (state_q == S_WLOW || state_q == S_WHIGH || state_q == S_WSET) begin
      gapCnt_d = gapCnt_q + 12'h001;
    end else begin
      gapCnt_d = 12'h000;
    end
    if (gapCnt_q >= BLC_SAFE_CYC) gapErr_d = 1'b1;
  end

  // pin levels follow the next state so strobes line up with the phases
  always_comb begin
    pins_d = MEM_PINS_IDLE;
    k      = itemIdx_d - preLen_d;
    case (state_d)
      S_WSET, S_WLOW, S_WHIGH: begin
        pins_d.ceN    = 1'b0;
        pins_d.oeN    = 1'b1;
        pins_d.weN    = (state_d != S_WLOW);
        pins_d.doutEn = 1'b1;
        if (itemIdx_d < preLen_d) begin
          pins_d.addr = {2'b00, cmdAddr(op_d == OP_LOCK_OFF, itemIdx_d[1:0])};
          pins_d.dout = cmdData(op_d == OP_LOCK_OFF, itemIdx_d[1:0]);
        end else begin
          pins_d.addr = {addrReg_q[16:7], 7'(addrReg_q[6:0] + k[6:0])};
          pins_d.dout = pageBuf_q[k[6:0]];
        end
      end
      S_RACC: begin
        pins_d.ceN = 1'b0; pins_d.oeN = 1'b0; pins_d.addr = rdAddr_d;
      end
      S_RGAP: begin
        pins_d.ceN = 1'b0; pins_d.addr = rdAddr_d;
      end
      default: begin
        pins_d = MEM_PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE; op_q <= OP_READ; pollData_q <= 1'b0; firstPoll_q <= 1'b1;
      prev6_q <= 1'b0; done_q <= 1'b0; timeout_q <= 1'b0; badCnt_q <= 1'b0;
      gapErr_q <= 1'b0; locked_q <= 1'b0; preLen_q <= 8'h00; itemIdx_q <= 8'h00;
      itemTotal_q <= 8'h00; lastData_q <= 8'h00; readByte_q <= 8'h00;
      rdAddr_q <= 17'h00000; progCnt_q <= 24'h0; gapCnt_q <= 12'h000;
      pins_q <= MEM_PINS_IDLE;
    end else begin
      state_q <= state_d; op_q <= op_d; pollData_q <= pollData_d; firstPoll_q <= firstPoll_d;
      prev6_q <= prev6_d; done_q <= done_d; timeout_q <= timeout_d; badCnt_q <= badCnt_d;
      gapErr_q <= gapErr_d; locked_q <= locked_d; preLen_q <= preLen_d;
      itemIdx_q <= itemIdx_d; itemTotal_q <= itemTotal_d; lastData_q <= lastData_d;
      readByte_q <= readByte_d; rdAddr_q <= rdAddr_d; progCnt_q <= progCnt_d;
      gapCnt_q <= gapCnt_d; pins_q <= pins_d;
    end
  end

  // checks on the pin protocol
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_pageConst;
    $fell(memPins.weN) && itemIdx_q >= preLen_q |-> memPins.addr[16:7] == addrReg_q[16:7];
  endproperty
  a_pageConst: assert property (p_pageConst) else $error("page address moved in a load");
  property p_gapBound;
    busy |-> gapCnt_q < BLC_SAFE_CYC;
  endproperty
  a_gapBound: assert property (p_gapBound) else $error("byte spacing too long");
  property p_gapStart;
    $fell(memPins.weN) |-> gapCnt_q == 12'h000 ##1 gapCnt_q == 12'h001;
  endproperty
  a_gapStart: assert property (p_gapStart) else $error("spacing counter not restarted");
  property p_countLegal;
    state_q == S_IDLE && goReq && goOp == OP_WRITE && !cntOk |=> state_q == S_IDLE && badCnt_q;
  endproperty
  a_countLegal: assert property (p_countLegal) else $error("bad byte count accepted");
  property p_cmdAddr;
    $fell(memPins.weN) && itemIdx_q < preLen_q
      |-> memPins.addr[14:0] == cmdAddr(op_q == OP_LOCK_OFF, itemIdx_q[1:0]);
  endproperty
  a_cmdAddr: assert property (p_cmdAddr) else $error("wrong command address");
  property p_cmdData;
    $fell(memPins.weN) && itemIdx_q < preLen_q
      |-> memPins.doutEn && memPins.dout == cmdData(op_q == OP_LOCK_OFF, itemIdx_q[1:0]);
  endproperty
  a_cmdData: assert property (p_cmdData) else $error("wrong command data");
  property p_oeHigh;
    !memPins.weN && !memPins.ceN |-> memPins.oeN;
  endproperty
  a_oeHigh: assert property (p_oeHigh) else $error("output enable low during strobe");
  property p_weWidth;
    $fell(memPins.weN) |-> !memPins.weN[*2] ##1 memPins.weN;
  endproperty
  a_weWidth: assert property (p_weWidth) else $error("write strobe width wrong");
  property p_toggleDone;
    state_q == S_RACC && tmrDone && op_q != OP_READ && !pollData_q && !firstPoll_q
      && memDin[6] == prev6_q |=> state_q == S_IDLE && done_q;
  endproperty
  a_toggleDone: assert property (p_toggleDone) else $error("stable bit six missed");
  property p_lockSet;
    state_q == S_RACC && tmrDone && op_q == OP_LOCK_ON && pollOk |=> locked_q;
  endproperty
  a_lockSet: assert property (p_lockSet) else $error("lock state not recorded");

  c_lockOn:  cover property (state_q == S_RACC ##1 state_q == S_IDLE && locked_q);
  c_protWr:  cover property (op_q == OP_WRITE && preLen_q == CMD_LEN && $rose(done_q));
  c_read:    cover property (op_q == OP_READ && $rose(done_q));
  c_timeout: cover property ($rose(timeout_q));
endmodule

/* File: tb/eeprom_model.sv */
// eeprom_model: behavioural paged eeprom with page load, lock and status polling.
// assumes registered host pins; falling sys_clk edges sample the pins and also step the internal timer.
`timescale 1ns/100ps
module eeprom_model #(
  parameter int          WIN  = 40,   // byte_load_window in clocks
  parameter int          PROG = 100,  // program_cycle_time in clocks
  parameter logic [44:0] ONA  = '0,   // lock-on addresses
  parameter logic [23:0] OND  = '0,   // lock-on data
  parameter logic [44:0] OFFA = '0,   // lock-off addresses
  parameter logic [23:0] OFFD = '0    // lock-off data
) (
  input  wire logic                      sys_clk,  // timer base
  input  wire eeprom_host_pkg::memPins_t pins,     // host strobes and buses
  output logic [7:0]                     dq        // device data lines
);
  import eeprom_host_pkg::*;
  logic [7:0]  mem [131072];
  logic [16:0] qa [$];
  logic [7:0]  qd [$];
  logic [7:0]  lastDat = 8'h00, lastDq = 8'h00;
  logic        prevWe = 1'b1, prevOe = 1'b1, tog = 1'b0, locked = 1'b0, onHit, offHit;
  int          cnt = 0, phase = 0, badPage = 0, badOe = 0, nBytes = 0, s;
  initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
  // byte latch, load window, programming and lock state
  // runs mid-cycle so data lines never move at the host's sampling edge
  always @(negedge sys_clk) begin
    if (!pins.ceN && !pins.weN && !pins.oeN) badOe++;
    if (!prevWe && pins.weN && !pins.ceN) begin
      qa.push_back(pins.addr);
      qd.push_back(pins.dout);
      lastDat = pins.dout;
      nBytes++;
      phase = 1;
      cnt = 0;
    end else if (phase == 1 && cnt >= WIN) begin
      phase = 2;
      cnt = 0;
    end else if (phase == 2 && cnt >= PROG) begin
      onHit = qa.size() > 2 && {qa[0][14:0], qa[1][14:0], qa[2][14:0]} == ONA
              && {qd[0], qd[1], qd[2]} == OND;
      offHit = qa.size() > 2 && {qa[0][14:0], qa[1][14:0], qa[2][14:0]} == OFFA
               && {qd[0], qd[1], qd[2]} == OFFD;
      s = (onHit || offHit) ? 3 : 0;
      for (int i = s; i < qa.size(); i++) begin
        if (qa[i][16:7] != qa[s][16:7]) badPage++;
        if (!offHit && (!locked || onHit)) mem[qa[i]] = qd[i];
      end
      locked = offHit ? 1'b0 : (onHit | locked);
      qa.delete();
      qd.delete();
      phase = 0;
    end else cnt++;
    if (prevOe && !pins.oeN && !pins.ceN) tog = ~tog;
    prevWe = pins.weN;
    prevOe = pins.oeN;
    lastDq = dq;
  end
  // status while busy, array when idle; released lines show a changing pattern
  always_comb begin
    if (!pins.ceN && !pins.oeN && pins.weN)
      dq = (phase != 0) ? {~lastDat[7], tog, lastDat[5:0]} : mem[pins.addr];
    else
      dq = ~lastDq;
  end
endmodule

/* File: tb/testbench.sv */
// testbench: drives the eeprom host over avalon-mm against the behavioural eeprom.
// assumes eeprom_host_pkg, the host and eeprom_model are compiled first.
`timescale 1ns/100ps
module testbench;
  import eeprom_host_pkg::*;
  // command triples shared by host and device model, values arbitrary
  localparam logic [44:0] ONA  = {15'h1555, 15'h0aaa, 15'h1555};
  localparam logic [23:0] OND  = {8'haa, 8'h55, 8'ha0};
  localparam logic [23:0] OFFD = {8'haa, 8'h55, 8'h20};
  typedef struct packed {logic [31:0] m; logic [31:0] v;} note_t;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  avsReq_t     avsReq  = '0;
  logic [31:0] avsReadData, rv;
  logic        avsWaitRequest;
  memPins_t    memPins;
  logic [7:0]  memDin, dq;
  note_t       notes [$];
  note_t       nt;
  int          n_fail = 0, checked = 0, seed = 39, nb;
  eeprom_write_host #(.PROG_TIMEOUT(400), .LOCK_ON_ADDR(ONA), .LOCK_ON_DATA(OND),
    .LOCK_OFF_ADDR(ONA), .LOCK_OFF_DATA(OFFD)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .avsReq(avsReq), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .memPins(memPins), .memDin(memDin));
  eeprom_model #(.WIN(40), .PROG(100), .ONA(ONA), .OND(OND), .OFFA(ONA), .OFFD(OFFD))
    i_mem (.sys_clk(sys_clk), .pins(memPins), .dq(dq));
  assign memDin = memPins.doutEn ? memPins.dout : dq;
  initial forever #25 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic [7:0] a, input logic r, input logic [31:0] w,
                      output logic [31:0] d);
    int n;
    n = 0;
    avsReq <= '{address: a, read: r, write: ~r, writeData: w};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 3000);
    if (avsWaitRequest !== 1'b0) begin
      n_fail++;
      test_done();
    end
    d = avsReadData;
    avsReq <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{m: m, v: v});
    xfer(a, 1'b1, 32'h0, rv);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] u;
    xfer(a, 1'b0, d, u);
  endtask
  // start a job, poll until done, then compare the whole status
  task automatic job(input logic [31:0] ctrl, input logic [31:0] st);
    int n;
    n = 0;
    wr(REG_CTRL, ctrl | (32'h1 << CTRL_GO));
    do begin
      rd(REG_STATUS, 32'h0, 32'h0);
      n++;
    end while (rv[ST_DONE] !== 1'b1 && n < 500);
    if (rv[ST_DONE] !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rd(REG_STATUS, 32'h3f, st);
  endtask
  // fill buffer with random bytes, write a page, compare the array afterwards
  task automatic page(input logic [16:0] b, input int c, input logic [31:0] ctrl,
                      input bit keep, input logic [31:0] st);
    logic [7:0] dat [128];
    logic [7:0] old [128];
    for (int i = 0; i < c; i++) begin
      dat[i] = 8'($random(seed)) & 8'h7f;
      old[i] = i_mem.mem[{b[16:7], 7'(b[6:0] + i)}];
      wr(8'h80 + 8'(i), {24'h0, dat[i]});
    end
    wr(REG_ADDR, {15'h0, b});
    wr(REG_COUNT, 32'(c));
    job(ctrl, st);
    for (int i = 0; i < c; i++)
      check(i_mem.mem[{b[16:7], 7'(b[6:0] + i)}], keep ? dat[i] : old[i]);
  endtask
  // result monitor: each read answer is matched against the oldest note
  always @(negedge sys_clk) begin
    if (avsReq.read === 1'b1 && avsWaitRequest === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      check(avsReadData & nt.m, nt.v);
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(REG_COUNT, 32'hff, 32'h1);
    rd(REG_STATUS, 32'h3f, 32'h0);
    rd(8'h10, 32'hffffffff, 32'h0);
    page({1'b0, 16'($random(seed))}, 128, 32'(OP_WRITE), 1, 32'h02);
    page(17'h1007f, 1, 32'(OP_WRITE) | 32'h10, 1, 32'h02);
    nb = i_mem.nBytes;
    for (int c = 0; c < 2; c++) begin
      wr(REG_COUNT, c ? 32'd129 : 32'd0);
      job(32'(OP_WRITE), 32'h0a);
    end
    check(32'(i_mem.nBytes), 32'(nb));
    job(32'(OP_LOCK_ON), 32'h12);
    check(32'(i_mem.locked), 32'h1);
    page(17'h18000, 4, 32'(OP_WRITE), 0, 32'h12);
    page(17'h18100, 2, 32'(OP_WRITE) | 32'h10, 0, 32'h16);
    page(17'h18205, 5, 32'(OP_WRITE) | 32'h20, 1, 32'h12);
    job(32'(OP_LOCK_OFF), 32'h02);
    check(32'(i_mem.locked), 32'h0);
    page(17'h18300, 3, 32'(OP_WRITE), 1, 32'h02);
    wr(REG_ADDR, 32'h18207);
    job(32'(OP_READ), 32'h02);
    rd(REG_RDATA, 32'hff, {24'h0, i_mem.mem[17'h18207]});
    check(32'(i_mem.badPage), 32'h0);
    check(32'(i_mem.badOe), 32'h0);
    test_done();
  end
endmodule
